// ==== design/gcmp_if.sv ====
// Interface between control logic and result path
`timescale 1ns/1ps
interface gcmp_if;
	logic ce;
	logic en;
	logic sel_ok;
	logic smp;
	logic inv;
	logic res_bit;
	logic res_fin;

	modport ctl (
		output ce,
		output en,
		output sel_ok,
		output smp,
		output inv,
		input res_bit,
		input res_fin
	);
	modport res (
		input ce,
		input en,
		input sel_ok,
		input smp,
		input inv,
		output res_bit,
		output res_fin
	);
endinterface

// ==== design/gcmp_pkg.sv ====
// Package of constants and types for the comparator control block
package gcmp_pkg;
	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;

	// Register indices and their byte addresses (index times four)
	localparam logic [7:0] SEL_IDX = 8'h22;
	localparam logic [7:0] CTL_IDX = 8'h3e;
	localparam logic [ADDR_W-1:0] SEL_ADDR = {SEL_IDX[5:0], 2'b00};
	localparam logic [ADDR_W-1:0] CTL_ADDR = {CTL_IDX[5:0], 2'b00};

	// Reset values
	localparam logic [REG_W-1:0] CTL_RST = 8'h00;
	localparam logic [REG_W-1:0] SEL_RST = 8'h00;

	// Control register fields
	localparam int CTL_EN_BIT = 7;
	localparam int CTL_RES_BIT = 6;
	localparam int CTL_SMP_BIT = 5;
	localparam int CTL_INV_BIT = 4;
	localparam int CTL_MSEL_LSB = 1;
	localparam int CTL_MSEL_W = 3;
	localparam int CTL_PSEL_BIT = 0;

	// Selection register fields
	localparam int SEL_OE_BIT = 7;
	localparam int SEL_WK_BIT = 6;
	localparam int SEL_RHI_BIT = 5;
	localparam int SEL_RLO_BIT = 4;
	localparam int SEL_LVL_LSB = 0;
	localparam int SEL_LVL_W = 4;

	// Minus input codes
	localparam logic [2:0] MSEL_PB_SECOND = 3'h0;
	localparam logic [2:0] MSEL_PB_FIRST = 3'h1;
	localparam logic [2:0] MSEL_BANDGAP = 3'h2;
	localparam logic [2:0] MSEL_LADDER = 3'h3;
	localparam logic [2:0] MSEL_PA_THIRD = 3'h4;
	localparam logic [2:0] MSEL_PA_FOURTH = 3'h5;
	localparam int MSEL_N = 6;

	// Pulse capture source code of the comparator result
	localparam logic [2:0] PCAP_SRC_CMP = 3'h5;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register hit codes
	localparam logic [1:0] HIT_NONE = 2'h0;
	localparam logic [1:0] HIT_SEL = 2'h1;
	localparam logic [1:0] HIT_CTL = 2'h2;

	// Write channel states
	typedef enum logic [1:0] {
		WR_IDLE,
		WR_ADDR,
		WR_DATA,
		WR_RESP
	} gcmp_wr_e;
endpackage

// ==== design/gcmp_resq.sv ====
// Comparator result path: synchronise, gate, sample, invert
`timescale 1ns/1ps
module gcmp_resq (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Asynchronous inputs
	input wire logic cmp_raw_in,
	input wire logic aux_timer_clock_in,
	// Control side
	gcmp_if.res bus
);
	typedef struct packed {
		logic raw_s1;
		logic raw_s2;
		logic aux_s1;
		logic aux_s2;
		logic aux_p;
		logic held;
		logic fin;
	} gcmp_resq_s;

	gcmp_resq_s q;
	gcmp_resq_s d;
	logic live;
	logic gated;
	logic pre;

	always_comb begin
		d = q;
		d.raw_s1 = cmp_raw_in;
		d.raw_s2 = q.raw_s1;
		d.aux_s1 = aux_timer_clock_in;
		d.aux_s2 = q.aux_s1;
		d.aux_p = q.aux_s2;
		live = bus.en && bus.sel_ok;
		gated = q.raw_s2 && live;
		if (q.aux_s2 && !q.aux_p) begin
			d.held = gated;
		end
		pre = bus.smp ? q.held : gated;
		d.fin = live ? (pre ^ bus.inv) : 1'b0;
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			q <= '0;
		end else if (bus.ce) begin
			q <= d;
		end
	end

	assign bus.res_bit = q.raw_s2 && bus.en && bus.sel_ok;
	assign bus.res_fin = q.fin;
endmodule

// ==== design/gcmp_top.sv ====
// Comparator control block with AXI4-Lite register slave
`timescale 1ns/1ps
module gcmp_top (
	// Clock, reset and enable
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	// AXI4-Lite write address
	input wire logic axi_awvalid_in,
	output logic axi_awready_out,
	input wire logic [gcmp_pkg::ADDR_W-1:0] axi_awaddr_in,
	input wire logic [2:0] axi_awprot_in,
	// AXI4-Lite write data
	input wire logic axi_wvalid_in,
	output logic axi_wready_out,
	input wire logic [gcmp_pkg::DATA_W-1:0] axi_wdata_in,
	input wire logic [3:0] axi_wstrb_in,
	// AXI4-Lite write response
	output logic axi_bvalid_out,
	input wire logic axi_bready_in,
	output logic [1:0] axi_bresp_out,
	// AXI4-Lite read address
	input wire logic axi_arvalid_in,
	output logic axi_arready_out,
	input wire logic [gcmp_pkg::ADDR_W-1:0] axi_araddr_in,
	input wire logic [2:0] axi_arprot_in,
	// AXI4-Lite read data
	output logic axi_rvalid_out,
	input wire logic axi_rready_in,
	output logic [gcmp_pkg::DATA_W-1:0] axi_rdata_out,
	output logic [1:0] axi_rresp_out,
	// Analog comparator
	input wire logic cmp_raw_in,
	output logic cmp_power_out,
	output logic [gcmp_pkg::MSEL_N-1:0] minus_sel_out,
	output logic plus_sel_pin_out,
	output logic ref_range_hi_out,
	output logic ref_range_lo_out,
	output logic [gcmp_pkg::SEL_LVL_W-1:0] ref_level_out,
	// Sampling clock
	input wire logic aux_timer_clock_in,
	// First port-B pin drive
	output logic portb_pin_first_out,
	output logic portb_pin_first_oe_out,
	// System wake-up
	output logic wake_out,
	// Pulse capture source
	input wire logic [2:0] pcap_src_sel_in,
	output logic pcap_cmp_out
);
	typedef struct packed {
		gcmp_pkg::gcmp_wr_e wr;
		logic [gcmp_pkg::ADDR_W-1:0] awaddr;
		logic [gcmp_pkg::REG_W-1:0] wdata;
		logic wlane;
		logic [1:0] bresp;
		logic rvalid;
		logic [gcmp_pkg::REG_W-1:0] rdata;
		logic [1:0] rresp;
		logic en;
		logic smp;
		logic inv;
		logic [gcmp_pkg::CTL_MSEL_W-1:0] msel;
		logic psel;
		logic oe;
		logic wk;
		logic rhi;
		logic rlo;
		logic [gcmp_pkg::SEL_LVL_W-1:0] lvl;
		logic [gcmp_pkg::MSEL_N-1:0] mhot;
		logic fin_p;
		logic wake;
		logic pcap;
	} gcmp_top_s;

	gcmp_top_s q;
	gcmp_top_s d;
	gcmp_top_s rst_val;

	gcmp_if link ();

	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic have_a;
	logic have_d;
	logic [gcmp_pkg::ADDR_W-1:0] addr_eff;
	logic [gcmp_pkg::REG_W-1:0] data_eff;
	logic lane_eff;
	logic [1:0] whit;
	logic [1:0] rhit;

	// Maps a byte address to the register it names
	function automatic logic [1:0] reg_hit(
		input logic [gcmp_pkg::ADDR_W-1:0] addr
	);
		logic [1:0] h;
		h = gcmp_pkg::HIT_NONE;
		if (addr[gcmp_pkg::ADDR_W-1:2] ==
				gcmp_pkg::SEL_ADDR[gcmp_pkg::ADDR_W-1:2]) begin
			h = gcmp_pkg::HIT_SEL;
		end else if (addr[gcmp_pkg::ADDR_W-1:2] ==
				gcmp_pkg::CTL_ADDR[gcmp_pkg::ADDR_W-1:2]) begin
			h = gcmp_pkg::HIT_CTL;
		end
		return h;
	endfunction

	// One-hot minus select; reserved codes give no selection
	function automatic logic [gcmp_pkg::MSEL_N-1:0] minus_hot(
		input logic [gcmp_pkg::CTL_MSEL_W-1:0] code
	);
		logic [gcmp_pkg::MSEL_N-1:0] m;
		m = '0;
		case (code)
			gcmp_pkg::MSEL_PB_SECOND: m[0] = 1'b1;
			gcmp_pkg::MSEL_PB_FIRST: m[1] = 1'b1;
			gcmp_pkg::MSEL_BANDGAP: m[2] = 1'b1;
			gcmp_pkg::MSEL_LADDER: m[3] = 1'b1;
			gcmp_pkg::MSEL_PA_THIRD: m[4] = 1'b1;
			gcmp_pkg::MSEL_PA_FOURTH: m[5] = 1'b1;
			default: m = '0;
		endcase
		return m;
	endfunction

	// Read image of the control register; bit 6 is the live result
	function automatic logic [gcmp_pkg::REG_W-1:0] ctl_image(
		input gcmp_top_s s,
		input logic res
	);
		logic [gcmp_pkg::REG_W-1:0] b;
		b = '0;
		b[gcmp_pkg::CTL_EN_BIT] = s.en;
		b[gcmp_pkg::CTL_RES_BIT] = res;
		b[gcmp_pkg::CTL_SMP_BIT] = s.smp;
		b[gcmp_pkg::CTL_INV_BIT] = s.inv;
		b[gcmp_pkg::CTL_MSEL_LSB +: gcmp_pkg::CTL_MSEL_W] = s.msel;
		b[gcmp_pkg::CTL_PSEL_BIT] = s.psel;
		return b;
	endfunction

	// Reset image of all state
	always_comb begin
		rst_val = '0;
		rst_val.wr = gcmp_pkg::WR_IDLE;
		rst_val.bresp = gcmp_pkg::RESP_OKAY;
		rst_val.rresp = gcmp_pkg::RESP_OKAY;
		rst_val.en = gcmp_pkg::CTL_RST[gcmp_pkg::CTL_EN_BIT];
		rst_val.smp = gcmp_pkg::CTL_RST[gcmp_pkg::CTL_SMP_BIT];
		rst_val.inv = gcmp_pkg::CTL_RST[gcmp_pkg::CTL_INV_BIT];
		rst_val.msel = gcmp_pkg::CTL_RST[gcmp_pkg::CTL_MSEL_LSB +:
			gcmp_pkg::CTL_MSEL_W];
		rst_val.psel = gcmp_pkg::CTL_RST[gcmp_pkg::CTL_PSEL_BIT];
		rst_val.oe = gcmp_pkg::SEL_RST[gcmp_pkg::SEL_OE_BIT];
		rst_val.wk = gcmp_pkg::SEL_RST[gcmp_pkg::SEL_WK_BIT];
		rst_val.rhi = gcmp_pkg::SEL_RST[gcmp_pkg::SEL_RHI_BIT];
		rst_val.rlo = gcmp_pkg::SEL_RST[gcmp_pkg::SEL_RLO_BIT];
		rst_val.lvl = gcmp_pkg::SEL_RST[gcmp_pkg::SEL_LVL_LSB +:
			gcmp_pkg::SEL_LVL_W];
		rst_val.mhot = minus_hot(rst_val.msel);
	end

	// Channel handshakes
	// Readies fall with the clock enable, so no request is lost while frozen
	// Pending responses stay up while frozen; the master must wait them out
	assign axi_awready_out = ce_in && ((q.wr == gcmp_pkg::WR_IDLE) ||
		(q.wr == gcmp_pkg::WR_DATA));
	assign axi_wready_out = ce_in && ((q.wr == gcmp_pkg::WR_IDLE) ||
		(q.wr == gcmp_pkg::WR_ADDR));
	assign axi_bvalid_out = (q.wr == gcmp_pkg::WR_RESP);
	assign axi_arready_out = ce_in && !q.rvalid;
	assign aw_hs = axi_awvalid_in && axi_awready_out;
	assign w_hs = axi_wvalid_in && axi_wready_out;
	assign ar_hs = axi_arvalid_in && axi_arready_out;

	always_comb begin
		d = q;
		have_a = aw_hs || (q.wr == gcmp_pkg::WR_ADDR);
		have_d = w_hs || (q.wr == gcmp_pkg::WR_DATA);
		addr_eff = aw_hs ? axi_awaddr_in : q.awaddr;
		data_eff = w_hs ? axi_wdata_in[gcmp_pkg::REG_W-1:0] : q.wdata;
		lane_eff = w_hs ? axi_wstrb_in[0] : q.wlane;
		whit = reg_hit(addr_eff);
		rhit = reg_hit(axi_araddr_in);

		// Write channel
		case (q.wr)
			gcmp_pkg::WR_RESP: begin
				if (axi_bready_in) begin
					d.wr = gcmp_pkg::WR_IDLE;
				end
			end
			default: begin
				if (aw_hs) begin
					d.awaddr = axi_awaddr_in;
				end
				if (w_hs) begin
					d.wdata = axi_wdata_in[gcmp_pkg::REG_W-1:0];
					d.wlane = axi_wstrb_in[0];
				end
				if (have_a && have_d) begin
					d.wr = gcmp_pkg::WR_RESP;
					d.bresp = gcmp_pkg::RESP_OKAY;
					if (whit == gcmp_pkg::HIT_NONE) begin
						d.bresp = gcmp_pkg::RESP_SLVERR;
					end else if (lane_eff && whit == gcmp_pkg::HIT_CTL) begin
						d.en = data_eff[gcmp_pkg::CTL_EN_BIT];
						d.smp = data_eff[gcmp_pkg::CTL_SMP_BIT];
						d.inv = data_eff[gcmp_pkg::CTL_INV_BIT];
						d.msel = data_eff[gcmp_pkg::CTL_MSEL_LSB +:
							gcmp_pkg::CTL_MSEL_W];
						d.psel = data_eff[gcmp_pkg::CTL_PSEL_BIT];
					end else if (lane_eff) begin
						d.oe = data_eff[gcmp_pkg::SEL_OE_BIT];
						d.wk = data_eff[gcmp_pkg::SEL_WK_BIT];
						d.rhi = data_eff[gcmp_pkg::SEL_RHI_BIT];
						d.rlo = data_eff[gcmp_pkg::SEL_RLO_BIT];
						d.lvl = data_eff[gcmp_pkg::SEL_LVL_LSB +:
							gcmp_pkg::SEL_LVL_W];
					end
				end else if (have_a) begin
					d.wr = gcmp_pkg::WR_ADDR;
				end else if (have_d) begin
					d.wr = gcmp_pkg::WR_DATA;
				end
			end
		endcase

		// Read channel; the selection register is write-only and reads zero
		if (q.rvalid && axi_rready_in) begin
			d.rvalid = 1'b0;
		end
		if (ar_hs) begin
			d.rvalid = 1'b1;
			d.rdata = '0;
			d.rresp = gcmp_pkg::RESP_OKAY;
			case (rhit)
				gcmp_pkg::HIT_CTL: begin
					d.rdata = ctl_image(q, link.res_bit);
				end
				gcmp_pkg::HIT_SEL: d.rdata = '0;
				default: d.rresp = gcmp_pkg::RESP_SLVERR;
			endcase
		end

		// Analog steering and result consumers
		d.mhot = minus_hot(d.msel);
		d.fin_p = link.res_fin;
		d.wake = q.wk && link.res_fin && !q.fin_p;
		d.pcap = (pcap_src_sel_in == gcmp_pkg::PCAP_SRC_CMP) &&
			link.res_fin;
	end

	// Reset wins over the clock enable; all state holds while it is low
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			q <= rst_val;
		end else if (ce_in) begin
			q <= d;
		end
	end

	// Control to the result path
	assign link.ce = ce_in;
	assign link.en = q.en;
	assign link.sel_ok = (q.mhot != '0);
	assign link.smp = q.smp;
	assign link.inv = q.inv;

	gcmp_resq u_resq (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.cmp_raw_in(cmp_raw_in),
		.aux_timer_clock_in(aux_timer_clock_in),
		.bus(link.res)
	);

	// Outputs
	assign axi_bresp_out = q.bresp;
	assign axi_rvalid_out = q.rvalid;
	assign axi_rdata_out = {{(gcmp_pkg::DATA_W-gcmp_pkg::REG_W){1'b0}},
		q.rdata};
	assign axi_rresp_out = q.rresp;
	assign cmp_power_out = q.en;
	assign minus_sel_out = q.mhot;
	assign plus_sel_pin_out = q.psel;
	assign ref_range_hi_out = q.rhi;
	assign ref_range_lo_out = q.rlo;
	assign ref_level_out = q.lvl;
	assign portb_pin_first_out = link.res_fin;
	assign portb_pin_first_oe_out = q.oe;
	assign wake_out = q.wake;
	assign pcap_cmp_out = q.pcap;
endmodule

// ==== verif/gcmp_checker.sv ====
// Assertion checker for the comparator control block
`timescale 1ns/1ps
module gcmp_checker (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Register bus
	input wire logic axi_arvalid_in,
	input wire logic axi_arready_out,
	input wire logic axi_rvalid_out,
	input wire logic axi_rready_in,
	input wire logic [31:0] axi_rdata_out,
	input wire logic axi_bvalid_out,
	input wire logic axi_bready_in,
	input wire logic [1:0] axi_bresp_out,
	// Comparator side
	input wire logic cmp_power_out,
	input wire logic [5:0] minus_sel_out,
	input wire logic plus_sel_pin_out,
	input wire logic ref_range_hi_out,
	input wire logic ref_range_lo_out,
	input wire logic [3:0] ref_level_out,
	input wire logic portb_pin_first_out,
	input wire logic wake_out,
	input wire logic [2:0] pcap_src_sel_in,
	input wire logic pcap_cmp_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	sequence s_ar;
		axi_arvalid_in && axi_arready_out;
	endsequence
	sequence s_rwait;
		axi_rvalid_out && !axi_rready_in;
	endsequence
	sequence s_off;
		!cmp_power_out [*6];
	endsequence
	property p_rlat;
		s_ar |=> axi_rvalid_out;
	endproperty
	property p_rhold;
		s_rwait |=> axi_rvalid_out && $stable(axi_rdata_out);
	endproperty
	property p_bhold;
		axi_bvalid_out && !axi_bready_in |=>
			axi_bvalid_out && $stable(axi_bresp_out);
	endproperty
	property p_onehot;
		$onehot0(minus_sel_out);
	endproperty
	property p_wonly;
		!$rose(axi_bvalid_out) |-> $stable({cmp_power_out, minus_sel_out,
			plus_sel_pin_out, ref_range_hi_out, ref_range_lo_out,
			ref_level_out});
	endproperty
	property p_off;
		s_off |-> !portb_pin_first_out && !pcap_cmp_out && !wake_out;
	endproperty
	property p_wake;
		wake_out |=> !wake_out;
	endproperty
	property p_pcap;
		pcap_cmp_out |-> $past(pcap_src_sel_in) == 3'h5;
	endproperty
	a_rlat: assert property (p_rlat)
		else $error("read answer late");
	a_rhold: assert property (p_rhold)
		else $error("read data not held");
	a_bhold: assert property (p_bhold)
		else $error("write response not held");
	a_onehot: assert property (p_onehot)
		else $error("minus select not one-hot");
	a_wonly: assert property (p_wonly)
		else $error("control output changed without write");
	a_off: assert property (p_off)
		else $error("result active while off");
	a_wake: assert property (p_wake)
		else $error("wake pulse too long");
	a_pcap: assert property (p_pcap)
		else $error("capture source wrong");
endmodule
bind gcmp_top gcmp_checker gcmp_checker_i (
	.clk_in(clk_in),
	.nrst_in(nrst_in),
	.axi_arvalid_in(axi_arvalid_in),
	.axi_arready_out(axi_arready_out),
	.axi_rvalid_out(axi_rvalid_out),
	.axi_rready_in(axi_rready_in),
	.axi_rdata_out(axi_rdata_out),
	.axi_bvalid_out(axi_bvalid_out),
	.axi_bready_in(axi_bready_in),
	.axi_bresp_out(axi_bresp_out),
	.cmp_power_out(cmp_power_out),
	.minus_sel_out(minus_sel_out),
	.plus_sel_pin_out(plus_sel_pin_out),
	.ref_range_hi_out(ref_range_hi_out),
	.ref_range_lo_out(ref_range_lo_out),
	.ref_level_out(ref_level_out),
	.portb_pin_first_out(portb_pin_first_out),
	.wake_out(wake_out),
	.pcap_src_sel_in(pcap_src_sel_in),
	.pcap_cmp_out(pcap_cmp_out)
);

// ==== verif/gcmp_top_tb_top.sv ====
// Testbench for the comparator control block
`timescale 1ns/1ps
module gcmp_top_tb_top;
	localparam logic [7:0] CA = gcmp_pkg::CTL_ADDR;
	localparam logic [7:0] SA = gcmp_pkg::SEL_ADDR;
	localparam logic [1:0] OK = gcmp_pkg::RESP_OKAY;
	localparam logic [1:0] ER = gcmp_pkg::RESP_SLVERR;
	logic clk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1;
	logic axi_awvalid_in = 1'b0, axi_wvalid_in = 1'b0;
	logic axi_bready_in = 1'b0, axi_arvalid_in = 1'b0;
	logic axi_rready_in = 1'b0, cmp_raw_in = 1'b0;
	logic aux_timer_clock_in = 1'b0;
	logic [7:0] axi_awaddr_in = 8'h00, axi_araddr_in = 8'h00;
	logic [2:0] axi_awprot_in = 3'h0, axi_arprot_in = 3'h0;
	logic [2:0] pcap_src_sel_in = 3'h0;
	logic [31:0] axi_wdata_in = 32'h0000_0000;
	logic [3:0] axi_wstrb_in = 4'h1, ws = 4'h1;
	logic axi_awready_out, axi_wready_out, axi_bvalid_out;
	logic axi_arready_out, axi_rvalid_out, cmp_power_out;
	logic plus_sel_pin_out, ref_range_hi_out, ref_range_lo_out;
	logic portb_pin_first_out, portb_pin_first_oe_out;
	logic wake_out, pcap_cmp_out;
	logic [1:0] axi_bresp_out, axi_rresp_out, rs;
	logic [31:0] axi_rdata_out, rd_q;
	logic [5:0] minus_sel_out;
	logic [3:0] ref_level_out;
	int n_mismatch = 0, n_compared = 0, n_wake = 0;
	gcmp_top gcmp_top_i (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.ce_in(ce_in),
		.axi_awvalid_in(axi_awvalid_in),
		.axi_awready_out(axi_awready_out),
		.axi_awaddr_in(axi_awaddr_in),
		.axi_awprot_in(axi_awprot_in),
		.axi_wvalid_in(axi_wvalid_in),
		.axi_wready_out(axi_wready_out),
		.axi_wdata_in(axi_wdata_in),
		.axi_wstrb_in(axi_wstrb_in),
		.axi_bvalid_out(axi_bvalid_out),
		.axi_bready_in(axi_bready_in),
		.axi_bresp_out(axi_bresp_out),
		.axi_arvalid_in(axi_arvalid_in),
		.axi_arready_out(axi_arready_out),
		.axi_araddr_in(axi_araddr_in),
		.axi_arprot_in(axi_arprot_in),
		.axi_rvalid_out(axi_rvalid_out),
		.axi_rready_in(axi_rready_in),
		.axi_rdata_out(axi_rdata_out),
		.axi_rresp_out(axi_rresp_out),
		.cmp_raw_in(cmp_raw_in),
		.cmp_power_out(cmp_power_out),
		.minus_sel_out(minus_sel_out),
		.plus_sel_pin_out(plus_sel_pin_out),
		.ref_range_hi_out(ref_range_hi_out),
		.ref_range_lo_out(ref_range_lo_out),
		.ref_level_out(ref_level_out),
		.aux_timer_clock_in(aux_timer_clock_in),
		.portb_pin_first_out(portb_pin_first_out),
		.portb_pin_first_oe_out(portb_pin_first_oe_out),
		.wake_out(wake_out),
		.pcap_src_sel_in(pcap_src_sel_in),
		.pcap_cmp_out(pcap_cmp_out)
	);
	always #2 clk_in = ~clk_in;
	always @(negedge clk_in) if (wake_out === 1'b1) n_wake++;
	task automatic complete_run();
		$display("Counts: %0d compared, %0d mismatched", n_compared,
			n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tmo();
		n_mismatch++;
		$display("MISMATCH bus wait exp answer got none");
		complete_run();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic wr(input logic [7:0] a, d, input logic [1:0] e);
		int k;
		logic ta, tw, hb;
		@(posedge clk_in);
		axi_awvalid_in <= 1'b1;
		axi_wvalid_in <= 1'b1;
		axi_awaddr_in <= a;
		axi_wdata_in <= {24'h00_0000, d};
		axi_wstrb_in <= ws;
		axi_bready_in <= 1'b1;
		hb = 1'b0;
		for (k = 0; k < 40 && !hb; k++) begin
			@(negedge clk_in);
			ta = axi_awvalid_in && axi_awready_out;
			tw = axi_wvalid_in && axi_wready_out;
			hb = axi_bvalid_out;
			rs = axi_bresp_out;
			@(posedge clk_in);
			if (ta) axi_awvalid_in <= 1'b0;
			if (tw) axi_wvalid_in <= 1'b0;
			if (hb) axi_bready_in <= 1'b0;
		end
		@(negedge clk_in);
		if (!hb) tmo();
		chk("bresp", e, rs);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] e);
		int k;
		logic ta, hr;
		@(posedge clk_in);
		axi_arvalid_in <= 1'b1;
		axi_araddr_in <= a;
		axi_rready_in <= 1'b1;
		hr = 1'b0;
		for (k = 0; k < 40 && !hr; k++) begin
			@(negedge clk_in);
			ta = axi_arvalid_in && axi_arready_out;
			hr = axi_rvalid_out;
			rd_q = axi_rdata_out;
			rs = axi_rresp_out;
			@(posedge clk_in);
			if (ta) axi_arvalid_in <= 1'b0;
			if (hr) axi_rready_in <= 1'b0;
		end
		@(negedge clk_in);
		if (!hr) tmo();
		chk("rresp", e, rs);
	endtask
	task automatic raw(input logic v, input logic c, input int n);
		@(posedge clk_in);
		cmp_raw_in <= v;
		aux_timer_clock_in <= c;
		cyc(n);
	endtask
	initial begin
		repeat (5) @(posedge clk_in);
		nrst_in <= 1'b1;
		rd(CA, OK);
		chk("ctl", 32'h0, rd_q);
		chk("power", 32'h0, cmp_power_out);
		chk("ref", 32'h0, {ref_range_hi_out, ref_range_lo_out});
		chk("level", 32'h0, ref_level_out);
		rd(SA, OK);
		chk("sel", 32'h0, rd_q);
		$display("Test reset done");
		for (int i = 0; i < 8; i++) begin
			wr(CA, {4'b1000, i[2:0], i[0]}, OK);
			cyc(1);
			chk("minus", (i < 6) ? 32'h1 << i : 32'h0,
				minus_sel_out);
			chk("plus", i[0], plus_sel_pin_out);
			chk("power", 32'h1, cmp_power_out);
		end
		$display("Test input select done");
		wr(SA, 8'hBF, OK);
		cyc(1);
		chk("sel", 32'h7F, {portb_pin_first_oe_out, ref_range_hi_out,
			ref_range_lo_out, ref_level_out});
		wr(SA, 8'h25, OK);
		ws = 4'h0;
		wr(SA, 8'hFF, OK);
		ws = 4'h1;
		wr(8'h10, 8'hFF, ER);
		rd(8'h10, ER);
		chk("unmapped", 32'h0, rd_q);
		cyc(1);
		chk("sel", 32'h25, {portb_pin_first_oe_out, ref_range_hi_out,
			ref_range_lo_out, ref_level_out});
		$display("Test select reg done");
		wr(SA, 8'h00, OK);
		wr(CA, 8'h86, OK);
		@(posedge clk_in);
		pcap_src_sel_in <= 3'h5;
		raw(1'b1, 1'b0, 6);
		rd(CA, OK);
		chk("result", 32'hC6, rd_q);
		chk("pin", 32'h1, portb_pin_first_out);
		chk("pcap", 32'h1, pcap_cmp_out);
		@(posedge clk_in);
		pcap_src_sel_in <= 3'h4;
		cyc(3);
		chk("pcap", 32'h0, pcap_cmp_out);
		wr(CA, 8'h96, OK);
		cyc(3);
		chk("pin", 32'h0, portb_pin_first_out);
		rd(CA, OK);
		chk("result", 32'hD6, rd_q);
		wr(CA, 8'h9C, OK);
		cyc(3);
		chk("pin", 32'h0, portb_pin_first_out);
		rd(CA, OK);
		chk("result", 32'h9C, rd_q);
		wr(CA, 8'h16, OK);
		cyc(3);
		chk("pin", 32'h0, portb_pin_first_out);
		rd(CA, OK);
		chk("result", 32'h16, rd_q);
		$display("Test result path done");
		wr(CA, 8'h86, OK);
		for (int w = 1; w >= 0; w--) begin
			wr(SA, {1'b0, w[0], 6'h00}, OK);
			raw(1'b0, 1'b0, 6);
			n_wake = 0;
			raw(1'b1, 1'b0, 8);
			chk("wake", w, n_wake);
		end
		$display("Test wake done");
		wr(CA, 8'hA6, OK);
		cyc(6);
		chk("smp", 32'h0, portb_pin_first_out);
		raw(1'b1, 1'b1, 8);
		chk("smp", 32'h1, portb_pin_first_out);
		raw(1'b0, 1'b1, 8);
		chk("smp", 32'h1, portb_pin_first_out);
		raw(1'b0, 1'b0, 4);
		raw(1'b0, 1'b1, 8);
		chk("smp", 32'h0, portb_pin_first_out);
		$display("Test sampling done");
		wr(CA, 8'h86, OK);
		cyc(3);
		chk("direct", 32'h0, portb_pin_first_out);
		@(posedge clk_in);
		ce_in <= 1'b0;
		raw(1'b1, 1'b0, 8);
		chk("frozen", 32'h0, portb_pin_first_out);
		@(posedge clk_in);
		ce_in <= 1'b1;
		cyc(6);
		chk("direct", 32'h1, portb_pin_first_out);
		$display("Test clock enable done");
		wr(SA, 8'hBF, OK);
		@(posedge clk_in);
		nrst_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		nrst_in <= 1'b1;
		rd(CA, OK);
		chk("ctl", 32'h0, rd_q);
		chk("power", 32'h0, cmp_power_out);
		chk("oe", 32'h0, portb_pin_first_oe_out);
		chk("minus", 32'h1, minus_sel_out);
		chk("ref", 32'h0, {ref_range_hi_out, ref_range_lo_out,
			ref_level_out});
		$display("Test second reset done");
		complete_run();
	end
endmodule
